// ==== design/otpl_access.v ====
// one-time area access over a single-lane serial command port
// assumes spi pins synchronous to clk_sys and sck well below half its rate
// assumes write latch and busy levels are kept by the surrounding command logic
// assumes the lock and data bytes survive reset, as the array is nonvolatile
`timescale 1ns/1ns
`include "otpl_map.vh"

module otpl_access (
  input  wire clk_sys,
  input  wire rstn,
  input  wire spi_sck,
  input  wire spi_cs_n,
  input  wire spi_si,
  output reg  spi_so,
  output reg  spi_so_oe,
  input  wire write_latch_flag,
  input  wire embedded_busy,
  output reg  write_latch_clear,
  output reg  program_done,
  output reg  program_refused
);

  // ****************************************
  // states and storage
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CMD   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_SKIP  = 3'h6;

  reg [7:0]  otp_mem [0:`OTPL_AREA_WORDS-1];
  reg        rst_meta_n;
  reg        rst_sync_n;
  reg        sck_q;
  reg        cs_q_n;
  reg [2:0]  state;
  reg [5:0]  bit_cnt;
  reg [7:0]  shift_in;
  reg [7:0]  shift_out;
  reg [23:0] addr;
  reg        is_prog;
  reg [1:0]  byte_cnt;
  reg [7:0]  wr_byte;

  // ****************************************
  // edge and frame detection
  // ****************************************
  // detectors reset to the idle levels, so no false edge follows reset
  wire sck_rise = spi_sck & ~sck_q;
  wire sck_fall = ~spi_sck & sck_q;
  wire cs_start = ~spi_cs_n & cs_q_n;
  wire cs_end   = spi_cs_n & ~cs_q_n;
  wire [7:0] next_shift_in = {shift_in[6:0], spi_si};

  // ****************************************
  // helpers
  // ****************************************
  // true on the final bit of a field; every phase counter ends the same way
  function last_bit;
    input [5:0] cnt;
    input [5:0] len;
    begin
      last_bit = (cnt == len - 6'h01);
    end
  endfunction

  function [8:0] otp_index;
    input [23:0] a;
    reg   [9:0]  d;
    begin
      d         = a[9:0] - `OTPL_AREA_BASE;
      otp_index = d[8:0];
    end
  endfunction

  // ****************************************
  // delivery state
  // ****************************************
  // every bit of the area reads as erased until programmed
  integer k;
  initial begin
    for (k = 0; k < `OTPL_AREA_WORDS; k = k + 1) begin
      otp_mem[k] = `OTPL_ERASED;
    end
  end

  // ****************************************
  // reset release
  // ****************************************
  // assertion takes hold at once; release waits two edges to settle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************
  // region decode for the programming address and the read pointer
  // ****************************************
  wire       prog_ok;
  wire       lock_used;
  wire [9:0] lock_addr;
  wire [2:0] lock_bit;
  wire [7:0] keep_mask;
  wire       rd_ok;

  otpl_region_map u_prog_map (
    .addr      (addr),
    .read_ok   (rd_ok),
    .prog_ok   (prog_ok),
    .lock_used (lock_used),
    .lock_addr (lock_addr),
    .lock_bit  (lock_bit),
    .keep_mask (keep_mask)
  );

  wire [7:0] lock_byte = otp_mem[otp_index({14'h0000, lock_addr})];
  wire       locked    = lock_used & ~lock_byte[lock_bit];
  wire [7:0] old_byte  = otp_mem[otp_index(addr)];
  // programming only pulls ones to zero, so a lock bit can never be restored
  wire [7:0] new_byte  = old_byte & (wr_byte | keep_mask);
  // out-of-range reads are don't-care; the erased value is sent there
  wire [7:0] rd_byte   = rd_ok ? old_byte : `OTPL_ERASED;

  // a frame cut inside a byte leaves bit_cnt above zero and is refused
  wire prog_frame = is_prog & (byte_cnt == `OTPL_ONE_BYTE)
                  & (bit_cnt == 6'h00) & (state == ST_WDATA);
  wire prog_go    = prog_frame & write_latch_flag & prog_ok & ~locked;

  // ****************************************
  // frame end classification
  // ****************************************
  // latch clear follows the framing alone, so a refused range or lock still clears it
  wire end_latch  = cs_end & prog_frame & write_latch_flag;
  wire end_commit = cs_end & prog_go;
  wire end_refuse = cs_end & is_prog & (state != ST_SKIP) & ~prog_go;

  // ****************************************
  // program commit at the end of the frame
  // ****************************************
  // no program time is modelled: the byte lands at deselect
  always @(posedge clk_sys) begin
    if (end_commit && rst_sync_n) begin
      otp_mem[otp_index(addr)] <= new_byte;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      write_latch_clear <= 1'b0;
      program_done      <= 1'b0;
      program_refused   <= 1'b0;
    end else begin
      write_latch_clear <= end_latch;
      program_done      <= end_commit;
      program_refused   <= end_refuse;
    end
  end

  // ****************************************
  // serial command sequencer
  // ****************************************
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sck_q     <= 1'b0;
      cs_q_n    <= 1'b1;
      state     <= ST_IDLE;
      bit_cnt   <= 6'h00;
      shift_in  <= 8'h00;
      shift_out <= 8'hFF;
      addr      <= 24'h000000;
      is_prog   <= 1'b0;
      byte_cnt  <= 2'h0;
      wr_byte   <= 8'hFF;
      spi_so    <= 1'b0;
      spi_so_oe <= 1'b0;
    end else begin
      sck_q  <= spi_sck;
      cs_q_n <= spi_cs_n;
      if (spi_cs_n) begin
        state     <= ST_IDLE;
        spi_so_oe <= 1'b0;
      end else if (cs_start) begin
        bit_cnt  <= 6'h00;
        byte_cnt <= 2'h0;
        is_prog  <= 1'b0;
        // an embedded algorithm owns the array: the whole frame is dropped
        state    <= embedded_busy ? ST_SKIP : ST_CMD;
      end else if (embedded_busy && (state != ST_SKIP)) begin
        // busy rising inside a frame drops the rest of it, before any commit
        state     <= ST_SKIP;
        spi_so_oe <= 1'b0;
      end else begin
        case (state)
          ST_CMD: begin
            if (sck_rise) begin
              shift_in <= next_shift_in;
              bit_cnt  <= bit_cnt + 6'h01;
              if (last_bit(bit_cnt, `OTPL_CMD_BITS)) begin
                bit_cnt <= 6'h00;
                if (next_shift_in == `OTPL_OP_PROGRAM) begin
                  is_prog <= 1'b1;
                  state   <= ST_ADDR;
                end else if (next_shift_in == `OTPL_OP_READ) begin
                  state   <= ST_ADDR;
                end else begin
                  // unknown opcodes sit out the frame with the output released
                  state   <= ST_SKIP;
                end
              end
            end
          end
          ST_ADDR: begin
            if (sck_rise) begin
              // address arrives msb first and is not cleared at frame start; all 24 bits shift in
              addr    <= {addr[22:0], spi_si};
              bit_cnt <= bit_cnt + 6'h01;
              if (last_bit(bit_cnt, `OTPL_ADDR_BITS)) begin
                bit_cnt <= 6'h00;
                state   <= is_prog ? ST_WDATA : ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            // dummy bits are counted; their values are ignored
            if (sck_rise) begin
              bit_cnt <= bit_cnt + 6'h01;
              if (last_bit(bit_cnt, `OTPL_DUMMY_BITS)) begin
                bit_cnt <= 6'h00;
                state   <= ST_RDATA;
              end
            end
          end
          ST_WDATA: begin
            if (sck_rise) begin
              shift_in <= next_shift_in;
              bit_cnt  <= bit_cnt + 6'h01;
              if (last_bit(bit_cnt, `OTPL_BYTE_BITS)) begin
                bit_cnt <= 6'h00;
                // only the last whole byte is kept; the count decides if it may land
                wr_byte <= next_shift_in;
                // saturate so that any count beyond one stays rejected
                if (byte_cnt != 2'h3) begin
                  byte_cnt <= byte_cnt + 2'h1;
                end
              end
            end
          end
          ST_RDATA: begin
            if (sck_fall) begin
              spi_so_oe <= 1'b1;
              bit_cnt   <= bit_cnt + 6'h01;
              // the first fall of each byte loads it from the pointer, later falls shift
              if (bit_cnt == 6'h00) begin
                spi_so    <= rd_byte[7];
                shift_out <= {rd_byte[6:0], 1'b1};
                // pointer climbs past the top; no wrap to the start
                addr      <= addr + 24'h000001;
              end else begin
                spi_so    <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b1};
              end
              if (last_bit(bit_cnt, `OTPL_BYTE_BITS)) begin
                bit_cnt <= 6'h00;
              end
            end
          end
          ST_SKIP: begin
            spi_so_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // otpl_access

// ==== design/otpl_map.vh ====
// constants for the one-time area access block: opcodes, framing, address map
// assumes spi mode 0 framing with msb first on every byte
`ifndef OTPL_MAP_VH
`define OTPL_MAP_VH

// ****************************************
// command opcodes and framing
// ****************************************
`define OTPL_OP_PROGRAM   8'h42
`define OTPL_OP_READ      8'h4B
`define OTPL_CMD_BITS     6'h08
`define OTPL_ADDR_BITS    6'h18
`define OTPL_DUMMY_BITS   6'h08
`define OTPL_BYTE_BITS    6'h08
`define OTPL_ONE_BYTE     2'h1

// ****************************************
// one-time area address map
// ****************************************
`define OTPL_AREA_LO      24'h000100
`define OTPL_AREA_HI      24'h0002FF
`define OTPL_AREA_BASE    10'h100
`define OTPL_RSVD         24'h000101
`define OTPL_LOCK_SN      10'h100
`define OTPL_SN_LO_FIRST  24'h000102
`define OTPL_SN_LO_LAST   24'h000109
`define OTPL_SN_HI_FIRST  24'h00010A
`define OTPL_SN_HI_LAST   24'h000111
`define OTPL_LOCK_U1      10'h112
`define OTPL_USER1_FIRST  24'h000114
`define OTPL_USER1_LAST   24'h000213
`define OTPL_LOCK_U17     10'h214
`define OTPL_LOCK_U25     10'h215
`define OTPL_USER17_FIRST 24'h000216
`define OTPL_USER17_LAST  24'h0002FF
`define OTPL_BIT_SN_LO    3'h0
`define OTPL_BIT_SN_HI    3'h1

// ****************************************
// fixed bits of lock bytes and fill values
// ****************************************
`define OTPL_KEEP_SN      8'hFC
`define OTPL_KEEP_U25     8'h80
`define OTPL_KEEP_NONE    8'h00
`define OTPL_ERASED       8'hFF
`define OTPL_AREA_WORDS   512

`endif

// ==== design/otpl_region_map.v ====
// region decode for the one-time area: range checks, lock byte and bit per address
// assumes a 24-bit byte address as received in the command's address phase
`timescale 1ns/1ns
`include "otpl_map.vh"

module otpl_region_map (
  input  wire [23:0] addr,
  output reg         read_ok,
  output reg         prog_ok,
  output reg         lock_used,
  output reg  [9:0]  lock_addr,
  output reg  [2:0]  lock_bit,
  output reg  [7:0]  keep_mask
);

  reg [23:0] offs;

  // inclusive span test shared by every region check
  function in_span;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_span = (a >= lo) && (a <= hi);
    end
  endfunction

  always @* begin
    offs      = 24'h000000;
    read_ok   = in_span(addr, `OTPL_AREA_LO, `OTPL_AREA_HI);
    prog_ok   = read_ok && (addr != `OTPL_RSVD);
    lock_used = 1'b0;
    lock_addr = `OTPL_LOCK_SN;
    lock_bit  = `OTPL_BIT_SN_LO;
    keep_mask = `OTPL_KEEP_NONE;
    if (addr == {14'h0000, `OTPL_LOCK_SN}) begin
      keep_mask = `OTPL_KEEP_SN;
    end else if (addr == {14'h0000, `OTPL_LOCK_U25}) begin
      keep_mask = `OTPL_KEEP_U25;
    end else if (in_span(addr, `OTPL_SN_LO_FIRST, `OTPL_SN_LO_LAST)) begin
      lock_used = 1'b1;
    end else if (in_span(addr, `OTPL_SN_HI_FIRST, `OTPL_SN_HI_LAST)) begin
      lock_used = 1'b1;
      lock_bit  = `OTPL_BIT_SN_HI;
    end else if (in_span(addr, `OTPL_USER1_FIRST, `OTPL_USER1_LAST)) begin
      // sixteen-byte regions 1..16, one lock bit each, two lock bytes
      offs      = addr - `OTPL_USER1_FIRST;
      lock_used = 1'b1;
      lock_addr = `OTPL_LOCK_U1 + {9'h000, offs[7]};
      lock_bit  = offs[6:4];
    end else if (in_span(addr, `OTPL_USER17_FIRST, `OTPL_USER17_LAST)) begin
      // regions 17..30 and the short region 31 share one stride of sixteen
      offs      = addr - `OTPL_USER17_FIRST;
      lock_used = 1'b1;
      lock_addr = `OTPL_LOCK_U17 + {9'h000, offs[7]};
      lock_bit  = offs[6:4];
    end
  end

endmodule // otpl_region_map

// ==== testbench/otpl_access_chk.sv ====
// checker: port-level properties of the one-time area access block
// assumes a bind to otpl_access and frames timed as the host model makes them
`timescale 1ns/1ns
module otpl_access_chk (
  input wire clk_sys,
  input wire rstn,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  input wire spi_so,
  input wire spi_so_oe,
  input wire write_latch_flag,
  input wire embedded_busy,
  input wire write_latch_clear,
  input wire program_done,
  input wire program_refused
);
  reg busy_frame;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****************************************
  // frame started while busy
  // ****************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      busy_frame <= 1'b0;
    else if ($fell(spi_cs_n))
      busy_frame <= embedded_busy;
  end
  // ****************************************
  // properties
  // ****************************************
  a_pulse_after_frame: assert property ((program_done || program_refused) |->
    spi_cs_n && $past(spi_cs_n) && !$past(spi_cs_n, 5)) else $error("pulse outside frame end");
  a_done_not_ref: assert property (program_done |-> !program_refused)
    else $error("done and refused together");
  a_clear_cause: assert property (write_latch_clear |-> write_latch_flag &&
    (program_done || program_refused)) else $error("latch clear without cause");
  a_done_clears: assert property (program_done |-> write_latch_clear)
    else $error("commit without latch clear");
  a_done_single: assert property (program_done |=> !program_done)
    else $error("done pulse too long");
  a_oe_release: assert property (spi_cs_n [*3] |-> !spi_so_oe)
    else $error("output enable after deselect");
  a_so_on_fall: assert property (spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |->
    !spi_sck && !spi_cs_n) else $error("data out changed off sck low");
  a_busy_quiet: assert property (busy_frame |->
    !program_done && !program_refused && !spi_so_oe) else $error("busy frame serviced");
  c_done: cover property (program_done);
  c_refused: cover property (program_refused && !write_latch_clear);
  c_read: cover property (spi_so_oe);
endmodule // otpl_access_chk

// ==== testbench/otpl_host.sv ====
// host model: single-lane serial master issuing one-time area commands
// assumes mode 0 and that tasks are called at a falling clk_sys edge
`timescale 1ns/1ns
`include "otpl_map.vh"
module otpl_host (
  input  wire clk_sys,
  input  wire spi_so,
  output reg  spi_sck,
  output reg  spi_cs_n,
  output reg  spi_si
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // sck low 4 clocks so data out has settled before the rise
  task bitx(input b, output r);
    begin
      spi_si = b;
      repeat (4) @(negedge clk_sys);
      r = spi_so;
      spi_sck = 1'b1;
      repeat (2) @(negedge clk_sys);
      spi_sck = 1'b0;
    end
  endtask
  // opcode, address, dummy byte on reads, then nb bytes from wd
  task frame(input [7:0] op, input [23:0] a, input [1:0] nb, input [15:0] wd,
             output [15:0] rd);
    reg [39:0] h;
    reg        r;
    integer    i;
    begin
      h = {op, a, 8'h00};
      rd = 16'h0000;
      spi_cs_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      for (i = 0; i < ((op == `OTPL_OP_READ) ? 40 : 32); i = i + 1)
        bitx(h[39-i], r);
      for (i = 0; i < nb * 8; i = i + 1) begin
        bitx(wd[15-i], r);
        rd = {rd[14:0], r};
      end
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule // otpl_host

// ==== testbench/tb_otpl_access.sv ====
// testbench: one-time area program, read, lock and refusal scenarios
// assumes the host model drives the serial pins; latch and busy driven here
`timescale 1ns/1ns
`include "otpl_map.vh"
module tb_otpl_access;
  localparam [2:0] p_done = 3'h6;
  localparam [2:0] p_rclr = 3'h5;
  localparam [2:0] p_ref  = 3'h1;
  reg        clk_sys, rstn, write_latch_flag, embedded_busy;
  wire       spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
  wire       write_latch_clear, program_done, program_refused;
  reg  [2:0] seen;
  reg        oe_seen;
  reg [15:0] rd;
  integer    n_fail, tests_run, cyc, i;
  otpl_access u_otpl_access (.clk_sys(clk_sys), .rstn(rstn), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .write_latch_flag(write_latch_flag), .embedded_busy(embedded_busy),
    .write_latch_clear(write_latch_clear), .program_done(program_done),
    .program_refused(program_refused));
  otpl_host u_otpl_host (.clk_sys(clk_sys), .spi_so(spi_so), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    seen <= seen | {write_latch_clear, program_done, program_refused};
    oe_seen <= oe_seen | spi_so_oe;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk3(input [2:0] got, input [2:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t pulses=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // pulses seen as {latch clear, done, refused}
  task prog(input [23:0] a, input [7:0] d, input [1:0] nb, input [2:0] exp);
    begin
      seen = 3'h0;
      u_otpl_host.frame(`OTPL_OP_PROGRAM, a, nb, {d, d}, rd);
      chk3(seen, exp);
    end
  endtask
  // a read must drive the output and raise no program pulse
  task rdb(input [23:0] a, input [7:0] exp);
    begin
      seen = 3'h0;
      oe_seen = 1'b0;
      u_otpl_host.frame(`OTPL_OP_READ, a, 2'h1, 16'h0000, rd);
      chk8(rd[7:0], exp);
      chk3({oe_seen, seen[1:0]}, 3'h4);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_basic;
    begin
      rdb(24'h000114, 8'hFF);
      prog(24'h000114, 8'hA5, 2'h1, p_done);
      rdb(24'h000114, 8'hA5);
      prog(24'h000114, 8'h5F, 2'h1, p_done);
      rdb(24'h000114, 8'h05);
    end
  endtask
  task t_latch_count;
    begin
      write_latch_flag = 1'b0;
      prog(24'h000115, 8'h00, 2'h1, p_ref);
      write_latch_flag = 1'b1;
      for (i = 0; i < 4; i = i + 2)
        prog(24'h000115, 8'h00, i[1:0], p_ref);
      rdb(24'h000115, 8'hFF);
    end
  endtask
  task t_range;
    begin
      prog(24'h000300, 8'h00, 2'h1, p_rclr);
      prog(24'h0000FF, 8'h00, 2'h1, p_rclr);
      prog(24'h000101, 8'h00, 2'h1, p_rclr);
      rdb(24'h000101, 8'hFF);
    end
  endtask
  task t_user_lock;
    begin
      prog(24'h000112, 8'hFE, 2'h1, p_done);
      prog(24'h000115, 8'h00, 2'h1, p_rclr);
      rdb(24'h000115, 8'hFF);
      prog(24'h000124, 8'h00, 2'h1, p_done);
      prog(24'h000112, 8'hFF, 2'h1, p_done);
      rdb(24'h000112, 8'hFE);
      prog(24'h000113, 8'h7F, 2'h1, p_done);
      prog(24'h000213, 8'h00, 2'h1, p_rclr);
    end
  endtask
  task t_serial_lock;
    begin
      prog(24'h000100, 8'h00, 2'h1, p_done);
      rdb(24'h000100, 8'hFC);
      prog(24'h000109, 8'h00, 2'h1, p_rclr);
      prog(24'h00010A, 8'h00, 2'h1, p_rclr);
    end
  endtask
  task t_high_lock;
    begin
      prog(24'h000215, 8'h00, 2'h1, p_done);
      rdb(24'h000215, 8'h80);
      prog(24'h0002FF, 8'h00, 2'h1, p_rclr);
      prog(24'h0002F5, 8'h00, 2'h1, p_rclr);
      prog(24'h000214, 8'hFE, 2'h1, p_done);
      prog(24'h000225, 8'h00, 2'h1, p_rclr);
      prog(24'h000226, 8'h00, 2'h1, p_done);
      rdb(24'h000226, 8'h00);
      u_otpl_host.frame(`OTPL_OP_READ, 24'h000225, 2'h2, 16'h0000, rd);
      chk8(rd[15:8], 8'hFF);
      chk8(rd[7:0], 8'h00);
    end
  endtask
  task t_busy;
    begin
      embedded_busy = 1'b1;
      prog(24'h000130, 8'h00, 2'h1, 3'h0);
      embedded_busy = 1'b0;
      rdb(24'h000130, 8'hFF);
      // busy rises in the address phase of a program frame
      fork
        prog(24'h000131, 8'h00, 2'h1, 3'h0);
        begin
          repeat (100) @(negedge clk_sys);
          embedded_busy = 1'b1;
        end
      join
      embedded_busy = 1'b0;
      rdb(24'h000131, 8'hFF);
    end
  endtask
  task results;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    rstn = 1'b0;
    write_latch_flag = 1'b1;
    embedded_busy = 1'b0;
    seen = 3'h0;
    oe_seen = 1'b0;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_basic;
    t_latch_count;
    t_range;
    t_user_lock;
    t_serial_lock;
    t_high_lock;
    t_busy;
    results;
  end
endmodule // tb_otpl_access
bind otpl_access otpl_access_chk u_otpl_access_chk (.clk_sys(clk_sys), .rstn(rstn),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
  .spi_so_oe(spi_so_oe), .write_latch_flag(write_latch_flag),
  .embedded_busy(embedded_busy), .write_latch_clear(write_latch_clear),
  .program_done(program_done), .program_refused(program_refused));
